// ### hdl/cfm_pkg.sv
// constants and carrier types of the chip fault monitor
// assumes one 100 MHz clock; the serial link pins and comparators are asynchronous

package cfm_pkg;

	// ==========================================================
	// wishbone register map (byte addresses)
	localparam logic [7:0] CFM_ADR_STATUS = 8'h00;
	localparam logic [7:0] CFM_ADR_DIAG1 = 8'h04;
	localparam logic [7:0] CFM_ADR_MASK = 8'h08;
	localparam logic [7:0] CFM_ADR_CONFIG = 8'h0C;
	localparam logic [7:0] CFM_ADR_IRQ_STAT = 8'h10;
	localparam logic [7:0] CFM_ADR_IRQ_MASK = 8'h14;
	localparam logic [7:0] CFM_ADR_FRAME = 8'h18;

	// ==========================================================
	// status word fields
	localparam int CFM_ST_POR = 0;
	localparam int CFM_ST_SE = 1;
	localparam int CFM_ST_OT = 2;
	localparam int CFM_ST_TW = 3;
	localparam int CFM_ST_FF = 15;
	// diagnostic register 1 fields
	localparam int CFM_D1_VRU = 0;
	localparam int CFM_D1_VRO = 1;
	// mask register fields, only the maskable monitors
	localparam int CFM_MSK_TW = 0;
	localparam int CFM_MSK_VRU = 1;
	localparam int CFM_MSK_VRO = 2;
	localparam logic [2:0] CFM_MASK_RST = 3'h0;
	// config register fields
	localparam int CFM_CFG_ESF = 0;
	localparam logic CFM_ESF_RST = 1'b1;

	// ==========================================================
	// interrupt events
	localparam int CFM_IRQ_W = 7;
	localparam int CFM_EV_POR = 0;
	localparam int CFM_EV_SE = 1;
	localparam int CFM_EV_OT = 2;
	localparam int CFM_EV_TW = 3;
	localparam int CFM_EV_VRU = 4;
	localparam int CFM_EV_VRO = 5;
	localparam int CFM_EV_FRM = 6;
	localparam logic [6:0] CFM_IRQ_MASK_RST = 7'h00;

	// ==========================================================
	// serial frame layout
	localparam int CFM_FRAME_W = 16;
	localparam logic [4:0] CFM_FRAME_EDGES = 5'h10;
	localparam logic [4:0] CFM_EDGE_SAT = 5'h11;
	localparam int CFM_FR_WR = 11;
	localparam int CFM_FR_ADR_LSB = 12;
	localparam logic [3:0] CFM_SADR_DIAG1 = 4'h2;

	typedef struct packed {
		logic over_temp;
		logic temp_warn;
		logic reg_under;
		logic reg_over;
	} cfm_mon_t;

	typedef struct packed {
		logic sck;
		logic frame_strobe_n;
		logic sdi;
	} cfm_link_t;

	typedef enum logic {CFM_PS_DOWN, CFM_PS_RUN} cfm_pwr_t;

endpackage

// ### hdl/cfm_chip_fault_monitor.sv
// chip fault monitor: latches chip and regulator faults, checks serial frames,
// gates the gate drive and reports over a classic wishbone slave
// assumes synchronous active-high rst_i is the internal power-on reset
//
// Chosen here: the address map and register access over Wishbone.

`timescale 1ns/1ps

module cfm_chip_fault_monitor
	import cfm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic logic_supply_ok_i,
	input wire cfm_mon_t mon_i,
	input wire cfm_link_t link_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic gate_enable_o,
	output logic sdo_o,
	output logic frame_valid_o,
	output logic [15:0] frame_word_o,
	output logic irq_o
);

	// ==========================================================
	// input synchronisers
	logic [7:0] sy1_r, sy2_r;
	logic [2:0] lnk_d_r;
	logic lsup_s;
	cfm_mon_t mon_s;
	cfm_link_t lnk_s;

	always_ff @(posedge clk_i)
	begin
		sy1_r <= {logic_supply_ok_i, mon_i, link_i};
		sy2_r <= sy1_r;
		lnk_d_r <= sy2_r[2:0];
	end

	assign lsup_s = sy2_r[7];
	assign mon_s = sy2_r[6:3];
	assign lnk_s = sy2_r[2:0];

	// ==========================================================
	// power state
	cfm_pwr_t pwr_r;
	logic go, hold, pwr_up;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pwr_r <= CFM_PS_DOWN;
		else
			unique case (pwr_r)
				CFM_PS_DOWN: if (lsup_s) pwr_r <= CFM_PS_RUN;
				CFM_PS_RUN: if (!lsup_s) pwr_r <= CFM_PS_DOWN;
			endcase
	end

	assign go = (pwr_r == CFM_PS_RUN);
	// everything but the supply monitor, the wishbone slave and the interrupt status rests while powered down
	assign hold = rst_i || !go;
	assign pwr_up = !rst_i && (pwr_r == CFM_PS_DOWN) && lsup_s;

	// ==========================================================
	// serial frame checker
	logic sck_rise, stb_fall, stb_rise, fr_err, fr_ok, clr_st, clr_d1;
	logic [4:0] edge_cnt_r;
	logic [15:0] shift_in_r, shift_out_r, st_word;

	assign sck_rise = lnk_s.sck && !lnk_d_r[2];
	assign stb_fall = !lnk_s.frame_strobe_n && lnk_d_r[1];
	assign stb_rise = lnk_s.frame_strobe_n && !lnk_d_r[1];
	assign fr_err = (edge_cnt_r != CFM_FRAME_EDGES) || !(^shift_in_r);
	assign fr_ok = go && stb_rise && !fr_err;
	assign clr_st = fr_ok && shift_in_r[CFM_FR_WR];
	assign clr_d1 = fr_ok && !shift_in_r[CFM_FR_WR] &&
		(shift_in_r[CFM_FR_ADR_LSB+:4] == CFM_SADR_DIAG1);

	always_ff @(posedge clk_i)
	begin
		if (hold || stb_fall)
		begin
			edge_cnt_r <= 5'h00;
			shift_in_r <= 16'h0000;
		end
		else if (sck_rise && !lnk_s.frame_strobe_n)
		begin
			if (edge_cnt_r != CFM_EDGE_SAT)
				edge_cnt_r <= edge_cnt_r + 5'h01;
			shift_in_r <= {shift_in_r[14:0], lnk_s.sdi};
		end
	end

	// status goes out msb first, so the summary flag is on sdo as soon as the strobe falls
	always_ff @(posedge clk_i)
	begin
		if (hold)
			shift_out_r <= 16'h0000;
		else if (stb_fall)
			shift_out_r <= st_word;
		else if (sck_rise && !lnk_s.frame_strobe_n)
			shift_out_r <= {shift_out_r[14:0], 1'b0};
	end

	always_ff @(posedge clk_i)
	begin
		if (hold)
		begin
			frame_valid_o <= 1'b0;
			frame_word_o <= 16'h0000;
		end
		else
		begin
			frame_valid_o <= fr_ok;
			if (fr_ok)
				frame_word_o <= shift_in_r;
		end
	end

	assign sdo_o = shift_out_r[15];

	// ==========================================================
	// software registers
	logic [2:0] mask_r;
	logic [6:0] irq_mask_r;
	logic esf_r, wb_take, wb_wr;

	assign wb_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_take && wb_we_i && wb_sel_i[0];

	always_ff @(posedge clk_i)
	begin
		if (hold)
		begin
			mask_r <= CFM_MASK_RST;
			esf_r <= CFM_ESF_RST;
			irq_mask_r <= CFM_IRQ_MASK_RST;
		end
		else if (wb_wr)
		begin
			if (wb_adr_i == CFM_ADR_MASK)
				mask_r <= wb_dat_i[2:0];
			if (wb_adr_i == CFM_ADR_CONFIG)
				esf_r <= wb_dat_i[CFM_CFG_ESF];
			if (wb_adr_i == CFM_ADR_IRQ_MASK)
				irq_mask_r <= wb_dat_i[6:0];
		end
	end

	// ==========================================================
	// fault flags
	logic por_f_r, se_f_r, ot_f_r, tw_f_r, vru_f_r, vro_f_r;
	logic tw_set, vru_set, vro_set, se_set;

	// power-on, serial error and overtemperature have no mask bit
	assign tw_set = mon_s.temp_warn && !mask_r[CFM_MSK_TW];
	assign vru_set = mon_s.reg_under && !mask_r[CFM_MSK_VRU];
	assign vro_set = mon_s.reg_over && !mask_r[CFM_MSK_VRO];
	assign se_set = go && stb_rise && fr_err;

	always_ff @(posedge clk_i)
	begin
		if (hold)
		begin
			por_f_r <= pwr_up;
			se_f_r <= 1'b0;
			ot_f_r <= 1'b0;
			tw_f_r <= 1'b0;
		end
		else
		begin
			// a set in the clearing cycle wins
			por_f_r <= por_f_r && !clr_st;
			se_f_r <= se_set || (se_f_r && !clr_st);
			ot_f_r <= mon_s.over_temp || (ot_f_r && !clr_st);
			tw_f_r <= tw_set || (tw_f_r && !clr_st);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (hold)
		begin
			vru_f_r <= 1'b0;
			vro_f_r <= 1'b0;
		end
		else
		begin
			vru_f_r <= vru_set || (vru_f_r && !clr_d1);
			vro_f_r <= vro_set || (vro_f_r && !clr_d1);
		end
	end

	always_comb
	begin
		st_word = 16'h0000;
		st_word[CFM_ST_POR] = por_f_r;
		st_word[CFM_ST_SE] = se_f_r;
		st_word[CFM_ST_OT] = ot_f_r;
		st_word[CFM_ST_TW] = tw_f_r;
		st_word[CFM_ST_FF] = por_f_r || se_f_r || ot_f_r || tw_f_r;
	end

	// ==========================================================
	// gate drive enable
	logic gate_nxt;

	// the supply level itself is used so the lockout bites in the same cycle
	assign gate_nxt = go && lsup_s
		&& !(mon_s.over_temp && esf_r)
		&& !(mon_s.reg_under && !mask_r[CFM_MSK_VRU]);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			gate_enable_o <= 1'b0;
		else
			gate_enable_o <= gate_nxt;
	end

	// ==========================================================
	// interrupts
	logic [6:0] irq_st_r, irq_ev;
	logic irq_rd;

	always_comb
	begin
		irq_ev = 7'h00;
		irq_ev[CFM_EV_POR] = pwr_up;
		irq_ev[CFM_EV_SE] = se_set;
		irq_ev[CFM_EV_OT] = go && mon_s.over_temp;
		irq_ev[CFM_EV_TW] = go && tw_set;
		irq_ev[CFM_EV_VRU] = go && vru_set;
		irq_ev[CFM_EV_VRO] = go && vro_set;
		irq_ev[CFM_EV_FRM] = fr_ok;
	end

	assign irq_rd = wb_take && !wb_we_i && (wb_adr_i == CFM_ADR_IRQ_STAT);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_st_r <= 7'h00;
		else
			irq_st_r <= irq_ev | (irq_rd ? 7'h00 : irq_st_r);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_st_r & irq_mask_r);
	end

	// ==========================================================
	// wishbone slave: ack one cycle after the request, unmapped reads zero
	logic [31:0] rd_mux;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (wb_adr_i)
			CFM_ADR_STATUS: rd_mux[15:0] = st_word;
			CFM_ADR_DIAG1: rd_mux[CFM_D1_VRO:CFM_D1_VRU] = {vro_f_r, vru_f_r};
			CFM_ADR_MASK: rd_mux[2:0] = mask_r;
			CFM_ADR_CONFIG: rd_mux[CFM_CFG_ESF] = esf_r;
			CFM_ADR_IRQ_STAT: rd_mux[6:0] = irq_st_r;
			CFM_ADR_IRQ_MASK: rd_mux[6:0] = irq_mask_r;
			CFM_ADR_FRAME: rd_mux[15:0] = frame_word_o;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_take;
			if (wb_take && !wb_we_i)
				wb_dat_o <= rd_mux;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_frame_bad;
		go && stb_rise && fr_err;
	endsequence
	sequence s_supply_back;
		(pwr_r == CFM_PS_DOWN) && lsup_s;
	endsequence
	property p_supply_off;
		!lsup_s |=> !gate_enable_o;
	endproperty
	a_supply_off: assert property (p_supply_off) else $error("gate on with supply low");
	property p_por_flags;
		s_supply_back |=> por_f_r && st_word[CFM_ST_FF] && go;
	endproperty
	a_por_flags: assert property (p_por_flags) else $error("power-on flags not set");
	// flags rest while powered down, so only a running block must latch overtemperature
	property p_ot_stop;
		(go && mon_s.over_temp && esf_r) |=> !gate_enable_o && ot_f_r;
	endproperty
	a_ot_stop: assert property (p_ot_stop) else $error("overtemp did not stop gates");
	property p_ot_nostop;
		(go && lsup_s && !esf_r && mon_s.over_temp && !mon_s.reg_under) |=> gate_enable_o;
	endproperty
	a_ot_nostop: assert property (p_ot_nostop) else $error("overtemp stopped gates");
	property p_ot_latched;
		(ot_f_r && go && lsup_s && !clr_st) |=> ot_f_r;
	endproperty
	a_ot_latched: assert property (p_ot_latched) else $error("overtemp flag lost");
	property p_frame_err;
		s_frame_bad ##0 (lsup_s) |=> se_f_r && !frame_valid_o;
	endproperty
	a_frame_err: assert property (p_frame_err) else $error("frame error not flagged");
	property p_err_keeps;
		s_frame_bad ##0 (lsup_s && tw_f_r && vro_f_r) |=> tw_f_r && vro_f_r;
	endproperty
	a_err_keeps: assert property (p_err_keeps) else $error("bad frame cleared flags");
	property p_vru_stop;
		(mon_s.reg_under && !mask_r[CFM_MSK_VRU] && go) |=> !gate_enable_o && vru_f_r;
	endproperty
	a_vru_stop: assert property (p_vru_stop) else $error("regulator under not acted");
	property p_vro_flag;
		(go && lsup_s && $rose(mon_s.reg_over) && !mask_r[CFM_MSK_VRO]) |=> vro_f_r;
	endproperty
	a_vro_flag: assert property (p_vro_flag) else $error("regulator over not flagged");
	// a clear or a power-down in the cycle before may legally drop the flag
	property p_tw_flag;
		(go && lsup_s && tw_set) |=> tw_f_r ##1 (tw_f_r || $past(clr_st) || !$past(go));
	endproperty
	a_tw_flag: assert property (p_tw_flag) else $error("warning flag not latched");
	property p_summary_out;
		(go && lsup_s && stb_fall) |=> (sdo_o == $past(st_word[CFM_ST_FF]));
	endproperty
	a_summary_out: assert property (p_summary_out) else $error("summary not shifted first");
endmodule

// ### sim/cfm_link_host.sv
// serial host model for the chip fault monitor link
// assumes the monitor samples the link with its own clock, unrelated in phase
`timescale 1ns/1ps
module cfm_link_host
	import cfm_pkg::*;
(
	input wire logic sdo_i,
	output cfm_link_t link_o
);
	logic first_bit;
	initial
	begin
		link_o = 3'b010;
		first_bit = 1'b0;
	end
	// ==========================================================
	// one frame of n rising edges, msb first; sck stands still between frames
	task automatic send(input logic [15:0] w, input int n);
		int k;
		// start just after the bench's edge: every later step is a multiple of 62.5 ns,
		// so no link pin ever moves on a rising clock edge
		#1;
		link_o.frame_strobe_n = 1'b0;
		#125;
		for (k = 0; k < n; k++)
		begin
			link_o.sdi = (k < 16) ? w[15 - k] : ~link_o.sdi;
			#62.5;
			if (k == 0)
				first_bit = sdo_i;
			link_o.sck = 1'b1;
			#62.5;
			link_o.sck = 1'b0;
		end
		#125;
		link_o.frame_strobe_n = 1'b1;
		// a released data line must not keep its last value
		link_o.sdi = ~link_o.sdi;
		#250;
	endtask
endmodule

// ### sim/test_chip_fault_monitor.sv
// bench of the chip fault monitor: wishbone master, comparators, link host
// assumes cfm_link_host drives the serial link with its own 125 ns clock
`timescale 1ns/1ps
module test_chip_fault_monitor
	import cfm_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic sup = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic [3:0] sel = 4'h0;
	logic [3:0] wsel = 4'hF;
	logic [31:0] q;
	logic [31:0] rdat;
	logic [31:0] seed = 32'h0000_8309;
	logic [15:0] w;
	logic [15:0] fword;
	logic ack, gate, sdo, fv, irq;
	cfm_mon_t mon = 4'h2;
	cfm_link_t link;
	int miscompares = 0;
	int n_compared = 0;
	int n_fv = 0;
	int i;

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i)
		if (fv === 1'b1)
			n_fv <= n_fv + 1;

	cfm_chip_fault_monitor dut_u (.clk_i(clk_i), .rst_i(rst_i), .logic_supply_ok_i(sup),
		.mon_i(mon), .link_i(link), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.gate_enable_o(gate), .sdo_o(sdo), .frame_valid_o(fv), .frame_word_o(fword),
		.irq_o(irq));
	cfm_link_host host_u (.sdo_i(sdo), .link_o(link));

	// ==========================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// odd parity in bit 0
	function automatic logic [15:0] fr(input logic [15:0] v);
		return {v[15:1], ~^v[15:1]};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic gt(input logic e);
		chk(32'(gate), 32'(e));
	endtask
	task automatic setm(input cfm_mon_t m);
		@(posedge clk_i);
		mon <= m;
		repeat (8) @(posedge clk_i);
	endtask
	task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int t;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		dat <= d;
		sel <= wsel;
		for (t = 0; t < 20; t++)
		begin
			@(posedge clk_i);
			if (ack === 1'b1)
				break;
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		sel <= 4'h0;
		if (t == 20)
		begin
			miscompares++;
			tally_and_finish();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==========================================================
	// scenarios
	initial
	begin
		repeat (2) @(posedge clk_i);
		gt(1'b0);
		rst_i <= 1'b0;
		sup <= 1'b1;
		repeat (8) @(posedge clk_i);
		gt(1'b0);
		rd(CFM_ADR_STATUS, 32'h0000_8001);
		rd(CFM_ADR_DIAG1, 32'h0000_0001);
		rd(CFM_ADR_CONFIG, 32'h0000_0001);
		setm(4'h0);
		gt(1'b1);
		rd(CFM_ADR_DIAG1, 32'h0000_0001);
		$display("power-up done");
		host_u.send(16'h2001, 16);
		chk(32'(host_u.first_bit), 32'h0000_0001);
		rd(CFM_ADR_DIAG1, 32'h0000_0001);
		rd(CFM_ADR_STATUS, 32'h0000_8003);
		host_u.send(16'h0800, 15);
		host_u.send(16'h0800, 17);
		rd(CFM_ADR_STATUS, 32'h0000_8003);
		chk(n_fv, 0);
		host_u.send(16'h2000, 16);
		rd(CFM_ADR_DIAG1, 32'h0000_0000);
		chk(32'(fword), 32'h0000_2000);
		host_u.send(16'h0800, 16);
		rd(CFM_ADR_STATUS, 32'h0000_0000);
		chk(n_fv, 2);
		$display("serial done");
		setm(4'h8);
		gt(1'b0);
		rd(CFM_ADR_STATUS, 32'h0000_8004);
		setm(4'h0);
		gt(1'b1);
		rd(CFM_ADR_STATUS, 32'h0000_8004);
		wb(1'b1, CFM_ADR_CONFIG, 32'h0000_0000);
		setm(4'h8);
		gt(1'b1);
		setm(4'h5);
		gt(1'b1);
		rd(CFM_ADR_STATUS, 32'h0000_800C);
		rd(CFM_ADR_DIAG1, 32'h0000_0002);
		wb(1'b1, CFM_ADR_MASK, 32'h0000_0002);
		setm(4'h2);
		gt(1'b1);
		rd(CFM_ADR_DIAG1, 32'h0000_0002);
		// bad-parity write and diag read while warning and overvoltage flags are latched
		host_u.send(16'h0801, 16);
		rd(CFM_ADR_STATUS, 32'h0000_800E);
		host_u.send(16'h2001, 16);
		rd(CFM_ADR_DIAG1, 32'h0000_0002);
		wb(1'b1, CFM_ADR_MASK, 32'h0000_0000);
		setm(4'h2);
		gt(1'b0);
		setm(4'h0);
		$display("monitors done");
		wb(1'b1, CFM_ADR_IRQ_MASK, 32'h0000_0040);
		wb(1'b0, CFM_ADR_IRQ_STAT, 32'h0000_0000);
		repeat (3) @(posedge clk_i);
		chk(32'(irq), 32'h0000_0000);
		host_u.send(16'h1234, 16);
		chk(32'(irq), 32'h0000_0001);
		wb(1'b0, CFM_ADR_IRQ_STAT, 32'h0000_0000);
		chk(q & 32'h0000_0040, 32'h0000_0040);
		repeat (3) @(posedge clk_i);
		chk(32'(irq), 32'h0000_0000);
		wb(1'b1, CFM_ADR_IRQ_MASK, 32'h0000_0000);
		host_u.send(16'h1234, 16);
		chk(32'(irq), 32'h0000_0000);
		$display("interrupt done");
		for (i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			wb(1'b1, CFM_ADR_MASK, seed);
			rd(CFM_ADR_MASK, seed & 32'h0000_0007);
			w = fr(seed[31:16]);
			host_u.send(w, 16);
			chk(32'(fword), 32'(w));
		end
		rd(8'h1C, 32'h0000_0000);
		// a write without the low byte lane must leave the mask alone
		wsel = 4'hE;
		wb(1'b1, CFM_ADR_MASK, ~seed);
		wsel = 4'hF;
		rd(CFM_ADR_MASK, seed & 32'h0000_0007);
		$display("random done");
		wb(1'b1, CFM_ADR_MASK, 32'h0000_0007);
		@(posedge clk_i);
		sup <= 1'b0;
		repeat (5) @(posedge clk_i);
		gt(1'b0);
		rd(CFM_ADR_STATUS, 32'h0000_0000);
		@(posedge clk_i);
		sup <= 1'b1;
		repeat (8) @(posedge clk_i);
		rd(CFM_ADR_STATUS, 32'h0000_8001);
		rd(CFM_ADR_CONFIG, 32'h0000_0001);
		rd(CFM_ADR_MASK, 32'h0000_0000);
		gt(1'b1);
		$display("supply loss done");
		tally_and_finish();
	end
endmodule
